// ### rtl/e3_oh_pkg.sv
// constants shared by both ends of the strobed overhead insertion link
// assumes one 100 MHz system clock shared by both ends
//
// Behaviour
// - strobe one line period before each overhead bit
// - frame pulse on last bit, with slot-0 strobe
// - capture insert bit on falling line clock
// - no request keeps the generated slot value
// - all 12 slots are insertable, so no request is discarded
// - captured bit goes into the next frame
// - terminal samples link on rising line clock
// - frame plus strobe marks first overhead slot
// - terminal counts strobes since frame marker
// - counts 0 to 9 are alignment bits 9..0
// - count 10 alarm bit, count 11 national bit
// - raise request and bit together at slot
// - hold request and bit until next strobe
package e3_oh_pkg;

    // ----------------------------------------------------------------
    // line timing
    // ----------------------------------------------------------------
    localparam int SYS_CLK_PERIOD_NS = 10;
    localparam logic [1:0] LINE_DIV_LAST = 2'h3;
    localparam logic [1:0] LINE_DIV_HALF = 2'h2;
    localparam logic [1:0] LINE_DIV_RESET = 2'h3;

    // ----------------------------------------------------------------
    // frame layout
    // ----------------------------------------------------------------
    localparam logic [10:0] FRAME_LAST_BIT = 11'h5ff;
    localparam logic [10:0] OH_SLOTS = 11'h00c;
    localparam logic [3:0] OH_SLOT_LAST = 4'hb;
    localparam logic [9:0] FAS_WORD = 10'h3d0;
    localparam logic [3:0] SLOT_ALARM = 4'ha;
    localparam logic [3:0] SLOT_NATIONAL = 4'hb;
    localparam logic [11:0] OH_INSERTABLE = 12'hfff;

    // ----------------------------------------------------------------
    // payload buffer
    // ----------------------------------------------------------------
    localparam int PAY_WIDTH = 8;
    localparam int PAY_DEPTH = 16;
    localparam logic [3:0] PAY_BIT_LAST = 4'h7;

    // ----------------------------------------------------------------
    // terminal states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        TERM_HUNT = 2'h1,
        TERM_LOCK = 2'h2
    } term_state_t;

    // bit index of an overhead slot inside the 12-bit overhead word
    function automatic logic [3:0] oh_index(input logic [3:0] slot);
        oh_index = OH_SLOT_LAST - slot;
    endfunction : oh_index

    // true while a frame position is an overhead slot
    function automatic logic is_oh(input logic [10:0] pos);
        is_oh = (pos < OH_SLOTS);
    endfunction : is_oh

endpackage : e3_oh_pkg

// ### rtl/e3_oh_link_if.sv
// link between framer end and terminal end
// assumes both ends run on the same system clock
`timescale 1ns/10ps
interface e3_oh_link_if;
    logic tx_line_clock;
    logic oh_slot_strobe;
    logic frame_boundary_pulse;
    logic oh_insert_request;
    logic oh_insert_bit;

    modport framer (
        output tx_line_clock,
        output oh_slot_strobe,
        output frame_boundary_pulse,
        input oh_insert_request,
        input oh_insert_bit
    );

    modport terminal (
        input tx_line_clock,
        input oh_slot_strobe,
        input frame_boundary_pulse,
        output oh_insert_request,
        output oh_insert_bit
    );
endinterface : e3_oh_link_if

// ### rtl/e3_oh_framer_end.sv
// framer end: line clock, slot strobes, overhead capture, serial output
// assumes synchronous user inputs and a terminal on the link interface
`timescale 1ns/10ps

// --------------------------------------------------------------------
// payload fifo
// --------------------------------------------------------------------
module e3_pay_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic [WIDTH-1:0] i_in_data,
    input wire logic i_in_valid,
    output logic o_in_ready,
    output logic [WIDTH-1:0] o_out_data,
    output logic o_out_valid,
    input wire logic i_out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] cnt_reg;
    logic [AW:0] cnt_next;
    logic in_ready_reg;
    logic out_valid_reg;
    wire push = i_in_valid & in_ready_reg;
    wire pop = i_out_ready & out_valid_reg;

    assign cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    assign o_in_ready = in_ready_reg;
    assign o_out_valid = out_valid_reg;
    assign o_out_data = mem_reg[rd_reg];

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
            in_ready_reg <= 1'b0;
            out_valid_reg <= 1'b0;
        end
        else
        begin
            if (push)
                wr_reg <= wr_reg + 1'b1;
            if (pop)
                rd_reg <= rd_reg + 1'b1;
            cnt_reg <= cnt_next;
            in_ready_reg <= (cnt_next != (AW+1)'(DEPTH));
            out_valid_reg <= (cnt_next != '0);
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (push)
            mem_reg[wr_reg] <= i_in_data;
    end
endmodule : e3_pay_fifo

// --------------------------------------------------------------------
// framer end
// --------------------------------------------------------------------
module e3_oh_framer_end (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic [7:0] i_pay_data,
    input wire logic i_pay_valid,
    output logic o_pay_ready,
    input wire logic i_gen_alarm_bit,
    input wire logic i_gen_national_bit,
    output logic o_line_data,
    output logic o_line_bit_valid,
    output logic o_underrun,
    e3_oh_link_if.framer link
);
    // ----------------------------------------------------------------
    // line clock divider
    // ----------------------------------------------------------------
    logic [1:0] div_reg;
    logic [1:0] div_next;
    logic line_clk_reg;
    wire rise_en = (div_reg == 2'h0);
    wire fall_en = (div_reg == e3_oh_pkg::LINE_DIV_HALF);

    assign div_next = (div_reg == e3_oh_pkg::LINE_DIV_LAST) ? 2'h0
                    : div_reg + 2'h1;

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            div_reg <= e3_oh_pkg::LINE_DIV_RESET;
            line_clk_reg <= 1'b0;
        end
        else
        begin
            div_reg <= div_next;
            line_clk_reg <= (div_next < e3_oh_pkg::LINE_DIV_HALF);
        end
    end

    // ----------------------------------------------------------------
    // frame position and strobes
    // ----------------------------------------------------------------
    logic [10:0] pos_reg;
    logic [10:0] pos_next;
    logic [10:0] pos_ahead;
    logic strobe_reg;
    logic frame_reg;

    assign pos_next = (pos_reg == e3_oh_pkg::FRAME_LAST_BIT) ? 11'h000
                    : pos_reg + 11'h001;
    assign pos_ahead = (pos_next == e3_oh_pkg::FRAME_LAST_BIT) ? 11'h000
                     : pos_next + 11'h001;

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            pos_reg <= e3_oh_pkg::FRAME_LAST_BIT - 11'h001;
            strobe_reg <= 1'b0;
            frame_reg <= 1'b0;
        end
        else if (rise_en)
        begin
            pos_reg <= pos_next;
            strobe_reg <= e3_oh_pkg::is_oh(pos_ahead);
            frame_reg <= (pos_next == e3_oh_pkg::FRAME_LAST_BIT);
        end
    end

    assign link.tx_line_clock = line_clk_reg;
    assign link.oh_slot_strobe = strobe_reg;
    assign link.frame_boundary_pulse = frame_reg;

    // ----------------------------------------------------------------
    // overhead capture and next-frame transfer
    // ----------------------------------------------------------------
    logic [11:0] pend_val_reg;
    logic [11:0] pend_mask_reg;
    logic [11:0] act_val_reg;
    logic [11:0] act_mask_reg;
    logic [11:0] cap_sel;
    wire [3:0] cur_idx = e3_oh_pkg::oh_index(pos_reg[3:0]);
    wire [3:0] next_idx = e3_oh_pkg::oh_index(pos_next[3:0]);
    wire cur_is_oh = e3_oh_pkg::is_oh(pos_reg);
    wire cap_en = fall_en & link.oh_insert_request & cur_is_oh
                & e3_oh_pkg::OH_INSERTABLE[cur_idx];
    wire frame_wrap = rise_en & (pos_next == e3_oh_pkg::FRAME_LAST_BIT);
    wire [11:0] gen_word = {e3_oh_pkg::FAS_WORD, i_gen_alarm_bit,
                            i_gen_national_bit};

    assign cap_sel = cap_en ? (12'h001 << cur_idx) : 12'h000;

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            pend_val_reg <= 12'h000;
            pend_mask_reg <= 12'h000;
            act_val_reg <= 12'h000;
            act_mask_reg <= 12'h000;
        end
        else if (frame_wrap)
        begin
            act_val_reg <= pend_val_reg;
            act_mask_reg <= pend_mask_reg;
            pend_mask_reg <= 12'h000;
        end
        else if (cap_en)
        begin
            pend_val_reg <= (pend_val_reg & ~cap_sel)
                          | (link.oh_insert_bit ? cap_sel : 12'h000);
            pend_mask_reg <= pend_mask_reg | cap_sel;
        end
    end

    // ----------------------------------------------------------------
    // payload serialiser
    // ----------------------------------------------------------------
    logic [7:0] fifo_data;
    logic fifo_valid;
    logic [7:0] sh_reg;
    logic [3:0] sh_cnt_reg;
    logic line_data_reg;
    logic line_valid_reg;
    logic underrun_reg;
    wire next_is_oh = e3_oh_pkg::is_oh(pos_next);
    wire pay_slot = rise_en & ~next_is_oh;
    wire need_word = pay_slot & (sh_cnt_reg == 4'h0);
    wire pop = need_word & fifo_valid;
    wire oh_bit = act_mask_reg[next_idx] ? act_val_reg[next_idx]
                : gen_word[next_idx];
    wire pay_bit = (sh_cnt_reg == 4'h0) ? (fifo_valid & fifo_data[7])
                 : sh_reg[7];

    e3_pay_fifo #(
        .WIDTH(e3_oh_pkg::PAY_WIDTH),
        .DEPTH(e3_oh_pkg::PAY_DEPTH)
    ) u_fifo (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .i_in_data(i_pay_data),
        .i_in_valid(i_pay_valid),
        .o_in_ready(o_pay_ready),
        .o_out_data(fifo_data),
        .o_out_valid(fifo_valid),
        .i_out_ready(pop)
    );

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            sh_reg <= 8'h00;
            sh_cnt_reg <= 4'h0;
            line_data_reg <= 1'b0;
            line_valid_reg <= 1'b0;
            underrun_reg <= 1'b0;
        end
        else
        begin
            line_valid_reg <= rise_en;
            underrun_reg <= need_word & ~fifo_valid;
            if (rise_en)
                line_data_reg <= next_is_oh ? oh_bit : pay_bit;
            if (pop)
            begin
                sh_reg <= {fifo_data[6:0], 1'b0};
                sh_cnt_reg <= e3_oh_pkg::PAY_BIT_LAST;
            end
            else if (pay_slot && sh_cnt_reg != 4'h0)
            begin
                sh_reg <= {sh_reg[6:0], 1'b0};
                sh_cnt_reg <= sh_cnt_reg - 4'h1;
            end
        end
    end

    assign o_line_data = line_data_reg;
    assign o_line_bit_valid = line_valid_reg;
    assign o_underrun = underrun_reg;
endmodule : e3_oh_framer_end

// ### rtl/e3_oh_terminal_end.sv
// terminal end: counts strobes and inserts one chosen overhead bit
// assumes the framer end drives the link on the same system clock
`timescale 1ns/10ps
module e3_oh_terminal_end (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_ins_enable,
    input wire logic [3:0] i_ins_slot,
    input wire logic i_ins_bit,
    output logic [3:0] o_slot_count,
    output logic o_frame_start,
    e3_oh_link_if.terminal link
);
    // ----------------------------------------------------------------
    // sampling and slot count
    // ----------------------------------------------------------------
    e3_oh_pkg::term_state_t state_reg;
    e3_oh_pkg::term_state_t state_next;
    logic prev_clk_reg;
    logic [3:0] cnt_reg;
    logic [3:0] cur_slot;
    logic req_reg;
    logic bit_reg;
    logic [3:0] slot_out_reg;
    logic frame_out_reg;
    wire sample = link.tx_line_clock & ~prev_clk_reg;
    wire marker = link.frame_boundary_pulse & link.oh_slot_strobe;
    wire strobe_seen = sample & link.oh_slot_strobe;
    wire locked = marker | (state_reg == e3_oh_pkg::TERM_LOCK);
    wire hit = strobe_seen & locked & i_ins_enable
             & (cur_slot == i_ins_slot);

    assign cur_slot = marker ? 4'h0 : cnt_reg + 4'h1;

    always_comb
    begin
        case (state_reg)
            e3_oh_pkg::TERM_HUNT:
                state_next = (sample & marker) ? e3_oh_pkg::TERM_LOCK
                           : e3_oh_pkg::TERM_HUNT;
            e3_oh_pkg::TERM_LOCK:
                state_next = e3_oh_pkg::TERM_LOCK;
            default:
                state_next = e3_oh_pkg::TERM_HUNT;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state_reg <= e3_oh_pkg::TERM_HUNT;
            prev_clk_reg <= 1'b0;
            cnt_reg <= 4'h0;
            slot_out_reg <= 4'h0;
            frame_out_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            prev_clk_reg <= link.tx_line_clock;
            frame_out_reg <= sample & marker;
            if (strobe_seen && locked)
            begin
                cnt_reg <= cur_slot;
                slot_out_reg <= cur_slot;
            end
        end
    end

    // ----------------------------------------------------------------
    // insert request
    // ----------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            req_reg <= 1'b0;
            bit_reg <= 1'b0;
        end
        else if (strobe_seen)
        begin
            req_reg <= hit;
            if (hit)
                bit_reg <= i_ins_bit;
        end
    end

    assign link.oh_insert_request = req_reg;
    assign link.oh_insert_bit = bit_reg;
    assign o_slot_count = slot_out_reg;
    assign o_frame_start = frame_out_reg;
endmodule : e3_oh_terminal_end

// ### sim/e3_oh_link_chk.sv
// checker on the link between framer end and terminal end
// assumes one system clock and the link signals as plain inputs
`timescale 1ns/10ps
module e3_oh_link_chk (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic tx_line_clock,
    input wire logic oh_slot_strobe,
    input wire logic frame_boundary_pulse,
    input wire logic oh_insert_request,
    input wire logic oh_insert_bit
);
    // ------------------------------------------------
    // helper counters
    // ------------------------------------------------
    logic [7:0] run_reg;
    logic [12:0] gap_reg;
    logic seen_reg;
    logic frame_q_reg;
    wire logic frame_rise = frame_boundary_pulse && !frame_q_reg;

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            run_reg <= 8'h00;
            gap_reg <= 13'h0000;
            seen_reg <= 1'b0;
            frame_q_reg <= 1'b0;
        end
        else
        begin
            run_reg <= oh_slot_strobe ? run_reg + 8'h01 : 8'h00;
            gap_reg <= frame_rise ? 13'h0001 : gap_reg + 13'h0001;
            seen_reg <= seen_reg | frame_rise;
            frame_q_reg <= frame_boundary_pulse;
        end
    end

    // ------------------------------------------------
    // assertions
    // ------------------------------------------------
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rstn);

    line_clk_a: assert property (
        $rose(tx_line_clock) |-> tx_line_clock ##1 tx_line_clock
        ##1 !tx_line_clock[*2] ##1 tx_line_clock)
        else $error("line clock not two high two low");
    strobe_edge_a: assert property (
        $changed(oh_slot_strobe) |-> tx_line_clock
        && $past(tx_line_clock) && !$past(tx_line_clock, 2))
        else $error("strobe moved off the line period");
    strobe_run_a: assert property (
        $fell(oh_slot_strobe) |-> run_reg == 8'h30)
        else $error("strobe run not twelve line periods");
    frame_len_a: assert property (
        $rose(frame_boundary_pulse) |->
        frame_boundary_pulse[*4] ##1 !frame_boundary_pulse)
        else $error("frame pulse not one line period");
    frame_strobe_a: assert property (
        $rose(frame_boundary_pulse) |-> $rose(oh_slot_strobe))
        else $error("frame pulse without first strobe");
    strobe_start_a: assert property (
        $rose(oh_slot_strobe) |-> frame_boundary_pulse)
        else $error("strobe run started without frame");
    frame_gap_a: assert property (
        frame_rise && seen_reg |-> gap_reg == 13'h1800)
        else $error("frame pulses not one frame apart");
    bit_hold_a: assert property (
        oh_insert_request && $past(oh_insert_request)
        |-> $stable(oh_insert_bit))
        else $error("insert bit moved during request");

    cover property ($rose(oh_insert_request));
    cover property ($fell(oh_slot_strobe));
    cover property (frame_rise && seen_reg);
endmodule : e3_oh_link_chk

// ### sim/tb_top.sv
// bench joining framer end and terminal end over the link
// assumes package, link interface, both ends and checker compiled first
`timescale 1ns/10ps
module tb_top;
    localparam logic [11:0] BASE = {e3_oh_pkg::FAS_WORD, 2'h1};
    logic i_sys_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic [7:0] pay_data = 8'h00;
    logic pay_valid = 1'b0;
    logic pay_ready;
    logic line_data;
    logic line_valid;
    logic underrun;
    logic ins_enable = 1'b0;
    logic [3:0] ins_slot = 4'h0;
    logic ins_bit = 1'b0;
    logic [3:0] slot_count;
    logic frame_start;
    int n_mismatch = 0;
    int tests_run = 0;
    int cycles = 0;
    int bpos = 5000;
    int cur_pos;
    logic prev_fr = 1'b0;

    e3_oh_link_if link ();
    e3_oh_framer_end i_e3_oh_framer_end (.i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn), .i_pay_data(pay_data), .i_pay_valid(pay_valid),
        .o_pay_ready(pay_ready), .i_gen_alarm_bit(1'b0),
        .i_gen_national_bit(1'b1), .o_line_data(line_data),
        .o_line_bit_valid(line_valid), .o_underrun(underrun), .link(link));
    e3_oh_terminal_end i_e3_oh_terminal_end (.i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn), .i_ins_enable(ins_enable), .i_ins_slot(ins_slot),
        .i_ins_bit(ins_bit), .o_slot_count(slot_count),
        .o_frame_start(frame_start), .link(link));
    e3_oh_link_chk i_e3_oh_link_chk (.i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn), .tx_line_clock(link.tx_line_clock),
        .oh_slot_strobe(link.oh_slot_strobe),
        .frame_boundary_pulse(link.frame_boundary_pulse),
        .oh_insert_request(link.oh_insert_request),
        .oh_insert_bit(link.oh_insert_bit));

    // ------------------------------------------------
    // clock, timeout and line bit position
    // ------------------------------------------------
    always #(e3_oh_pkg::SYS_CLK_PERIOD_NS / 2) i_sys_clk = ~i_sys_clk;
    assign cur_pos = prev_fr ? 0 : bpos + 1;

    always @(posedge i_sys_clk)
    begin
        cycles++;
        if (line_valid)
        begin
            bpos <= cur_pos;
            prev_fr <= link.frame_boundary_pulse;
        end
        if (cycles == 70000)
        begin
            n_mismatch++;
            finish_test();
        end
    end

    // ------------------------------------------------
    // shared tasks
    // ------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test

    task automatic tick();
        @(posedge i_sys_clk);
        #1;
    endtask : tick

    task automatic get_oh(output logic [11:0] w);
        int n;
        n = 0;
        w = 12'h000;
        for (int i = 0; i < 8000 && n < 12; i++)
        begin
            tick();
            if (line_valid === 1'b1 && cur_pos == n)
            begin
                w[11 - n] = line_data;
                n++;
            end
        end
        check(16'(n), 16'h000c);
    endtask : get_oh

    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    task automatic t_marker();
        for (int i = 0; i < 8000 && frame_start !== 1'b1; i++)
            tick();
        check(16'(frame_start), 16'h0001);
        tick();
        check(16'(slot_count), 16'h0000);
        repeat (40) tick();
        check(16'(slot_count), 16'h000a);
        repeat (4) tick();
        check(16'(slot_count), 16'h000b);
    endtask : t_marker

    task automatic t_payload();
        int n;
        logic full;
        logic took;
        logic go;
        logic stop;
        logic [7:0] b;
        logic bits[$];
        n = 0;
        full = 1'b0;
        go = 1'b0;
        stop = 1'b0;
        fork
            begin
                pay_valid = 1'b1;
                pay_data = 8'h80;
                for (int i = 0; i < 40 && !full; i++)
                begin
                    took = pay_ready;
                    tick();
                    if (took === 1'b1)
                        n++;
                    else
                        full = 1'b1;
                    pay_data = 8'h80 | 8'(n);
                end
                pay_valid = 1'b0;
            end
            for (int i = 0; i < 3000 && !stop; i++)
            begin
                tick();
                stop = go && (underrun === 1'b1);
                if (line_valid === 1'b1 && cur_pos >= 12)
                begin
                    go = go | (line_data === 1'b1);
                    if (go)
                        bits.push_back(line_data);
                end
            end
        join
        check(16'(full), 16'h0001);
        check(16'(n >= 16), 16'h0001);
        check(16'(stop), 16'h0001);
        for (int k = 0; k < n && 8 * k + 7 < bits.size(); k++)
        begin
            for (int j = 0; j < 8; j++)
                b = {b[6:0], bits[8 * k + j]};
            check(16'(b), 16'(8'h80 | 8'(k)));
        end
    endtask : t_payload

    task automatic t_insert(input logic [3:0] s, input logic [11:0] prev,
                            output logic [11:0] exp);
        logic [11:0] w;
        exp = BASE ^ (12'h800 >> s);
        ins_slot = s;
        ins_bit = exp[4'hb - s];
        ins_enable = 1'b1;
        get_oh(w);
        check(16'(w), 16'(prev));
        get_oh(w);
        check(16'(w), 16'(exp));
    endtask : t_insert

    initial
    begin
        logic [11:0] e;
        logic [11:0] w;
        repeat (3) @(posedge i_sys_clk);
        #1;
        i_rstn = 1'b1;
        t_marker();
        get_oh(w);
        check(16'(w), 16'(BASE));
        t_payload();
        t_insert(4'h0, BASE, e);
        t_insert(4'ha, e, e);
        t_insert(4'hb, e, e);
        ins_enable = 1'b0;
        get_oh(w);
        check(16'(w), 16'(e));
        get_oh(w);
        check(16'(w), 16'(BASE));
        finish_test();
    end
endmodule : tb_top
